//--- hw/dao_pkg.sv
// Function
// - Threshold selection asserts condition while monitored value is above the output level.
// - Each output owns a level, 0.0 to 819.2 in 0.1 steps, default 0.0.
// - Changing selection keeps the level and compares it at once with the new quantity.
// - Frequency selection compares inclusively: value greater than or equal to level.
// - Current, torque, temperature, bus and loop error selections compare strictly greater.
// - Input-link selection energizes output while linked input is closed, else de-energizes.
// - Input tracking only when linked input is in use and link selection matches.
// - Linked output keeps tracking even if the input also serves another function.
// - Condition going true waits the ON delay before the output changes.
// - Condition going false waits the OFF delay before the output changes.
// - Delay of zero disables that timer; output follows the transition directly.
// - Condition reverting while a timer runs cancels it; output stays unchanged.
// - ON delay per output is 0.0 to 600.0 s in 0.1 s steps, default 0.0.
// - OFF delay per output is 0.0 to 600.0 s in 0.1 s steps, default 0.0.
// - Selected condition decides whether a transition energizes or de-energizes the relay.
// - Each output has its own ON and OFF timers, none shared.
// - Fault and alarm selections hold relay energized normally, de-energized when present.
package dao_pkg;
	localparam int NUM_OUT = 2;
	localparam int NUM_DIN = 6;
	localparam int NUM_MON = 6;
	localparam int SEL_W = 5;
	localparam int SEL_COUNT = 27;
	localparam int LVL_W = 14;
	localparam int DLY_W = 13;
	localparam int TCK_W = 24;
	// Selection codes
	localparam logic [SEL_W-1:0] SEL_FAULT = 5'h01;
	localparam logic [SEL_W-1:0] SEL_ALARM = 5'h02;
	localparam logic [SEL_W-1:0] SEL_FREQ = 5'h0a;
	localparam logic [SEL_W-1:0] SEL_THR_FIRST = 5'h0a;
	localparam logic [SEL_W-1:0] SEL_THR_LAST = 5'h0f;
	localparam logic [SEL_W-1:0] SEL_LINK_FIRST = 5'h15;
	localparam logic [SEL_W-1:0] SEL_LINK_LAST = 5'h1a;
	// Limits in tenths
	localparam logic [LVL_W-1:0] LVL_MAX = 14'h2000;
	localparam logic [DLY_W-1:0] DLY_MAX = 13'h1770;
	localparam logic [LVL_W-1:0] LVL_RST = 14'h0000;
	localparam logic [DLY_W-1:0] DLY_RST = 13'h0000;
	// Tick timing
	localparam longint TICK_NS = 100000000;
	localparam longint CLK_PERIOD_NS = 8;
	localparam int TICK_CYCLES_DEF = int'(TICK_NS / CLK_PERIOD_NS);
	// Register byte offsets
	localparam logic [7:0] ADDR_SEL0 = 8'h00;
	localparam logic [7:0] ADDR_SEL1 = 8'h04;
	localparam logic [7:0] ADDR_LVL0 = 8'h08;
	localparam logic [7:0] ADDR_LVL1 = 8'h0c;
	localparam logic [7:0] ADDR_ON0 = 8'h10;
	localparam logic [7:0] ADDR_ON1 = 8'h14;
	localparam logic [7:0] ADDR_OFF0 = 8'h18;
	localparam logic [7:0] ADDR_OFF1 = 8'h1c;
	localparam logic [7:0] ADDR_INUSE = 8'h20;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	// Status register fields
	localparam int STAT_ACC_LSB = 0;
	localparam int STAT_COND_LSB = 2;
	localparam int STAT_RELAY_LSB = 4;
	localparam int STAT_DIN_LSB = 8;

	typedef struct packed {
		logic [NUM_OUT-1:0][SEL_W-1:0] sel;
		logic [NUM_OUT-1:0][LVL_W-1:0] level;
		logic [NUM_OUT-1:0][DLY_W-1:0] on_dly;
		logic [NUM_OUT-1:0][DLY_W-1:0] off_dly;
		logic [NUM_DIN-1:0] in_used;
		logic [NUM_OUT-1:0] acc;
		logic [NUM_OUT-1:0][DLY_W-1:0] cnt;
		logic [TCK_W-1:0] tick_cnt;
		logic tick;
		logic [NUM_DIN-1:0] din_m;
		logic [NUM_DIN-1:0] din_s;
		logic [NUM_OUT-1:0] relay;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dao_state_s;

	localparam dao_state_s ST_RST = '0;
endpackage

//--- hw/dao_top.sv
`timescale 1ns/1ps
module dao_top
	import dao_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input wire logic pclk, // 125 MHz clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [SEL_COUNT-1:0] status_cond, // Status conditions by selection code
	input wire logic [NUM_MON-1:0][LVL_W-1:0] mon_val, // Monitored values in tenths
	input wire logic [NUM_DIN-1:0] din, // Digital input pins, high = closed
	output logic [NUM_OUT-1:0] relay // Relay drive, high = energized
);
	dao_state_s st_q;
	dao_state_s st_d;
	logic [NUM_OUT-1:0] cond;
	logic [NUM_OUT-1:0] invert;
	logic access;
	logic wr_commit;

	generate
		for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
			logic [SEL_W-1:0] s;
			logic [2:0] ti;
			logic [2:0] li;
			logic is_thr;
			logic is_link;
			logic thr_hit;
			logic link_hit;
			assign s = st_q.sel[i];
			assign ti = 3'(s - SEL_THR_FIRST);
			assign li = 3'(s - SEL_LINK_FIRST);
			assign is_thr = (s >= SEL_THR_FIRST) && (s <= SEL_THR_LAST);
			assign is_link = (s >= SEL_LINK_FIRST) && (s <= SEL_LINK_LAST);
			// Level is read fresh each cycle, so a new selection is judged at once
			assign thr_hit = is_thr && ((s == SEL_FREQ) ? (mon_val[ti] >= st_q.level[i])
				: (mon_val[ti] > st_q.level[i]));
			// Input function assignment is not looked at here, only its use
			assign link_hit = is_link && st_q.in_used[li] && st_q.din_s[li];
			assign cond[i] = is_thr ? thr_hit
				: is_link ? link_hit
				: (s < SEL_COUNT) && status_cond[s];
			assign invert[i] = (s == SEL_FAULT) || (s == SEL_ALARM);
		end
	endgenerate

	assign access = psel && penable;
	assign wr_commit = access && st_q.pready && pwrite;

	always_comb begin
		logic [DLY_W-1:0] dly;
		logic [LVL_W-1:0] wl;
		logic [DLY_W-1:0] wd;
		dly = DLY_RST;
		wl = (pwdata[LVL_W-1:0] > LVL_MAX) ? LVL_MAX : pwdata[LVL_W-1:0];
		wd = (pwdata[DLY_W-1:0] > DLY_MAX) ? DLY_MAX : pwdata[DLY_W-1:0];
		st_d = st_q;
		st_d.din_m = din;
		st_d.din_s = st_q.din_m;
		// Tick divider
		st_d.tick = 1'b0;
		if (st_q.tick_cnt >= TCK_W'(TICK_CYCLES - 1)) begin
			st_d.tick_cnt = '0;
			st_d.tick = 1'b1;
		end else begin
			st_d.tick_cnt = st_q.tick_cnt + TCK_W'(1);
		end
		// Per-output delay timers
		for (int i = 0; i < NUM_OUT; i++) begin
			if (cond[i] == st_q.acc[i]) begin
				st_d.cnt[i] = '0;
			end else begin
				dly = cond[i] ? st_q.on_dly[i] : st_q.off_dly[i];
				if (dly == DLY_RST) begin
					st_d.acc[i] = cond[i];
					st_d.cnt[i] = '0;
				end else if (st_q.tick) begin
					if (st_q.cnt[i] + DLY_W'(1) >= dly) begin
						st_d.acc[i] = cond[i];
						st_d.cnt[i] = '0;
					end else begin
						st_d.cnt[i] = st_q.cnt[i] + DLY_W'(1);
					end
				end
			end
			st_d.relay[i] = st_d.acc[i] ^ invert[i];
		end
		// APB: one wait state, data and error prepared before ready
		// Error only stands beside ready, so a stale refusal never leaks into idle cycles
		st_d.pslverr = 1'b0;
		st_d.pready = access && !st_q.pready;
		if (access && !st_q.pready) begin
			st_d.pslverr = 1'b0;
			st_d.prdata = '0;
			case (paddr)
				ADDR_SEL0: st_d.prdata = 32'(st_q.sel[0]);
				ADDR_SEL1: st_d.prdata = 32'(st_q.sel[1]);
				ADDR_LVL0: st_d.prdata = 32'(st_q.level[0]);
				ADDR_LVL1: st_d.prdata = 32'(st_q.level[1]);
				ADDR_ON0: st_d.prdata = 32'(st_q.on_dly[0]);
				ADDR_ON1: st_d.prdata = 32'(st_q.on_dly[1]);
				ADDR_OFF0: st_d.prdata = 32'(st_q.off_dly[0]);
				ADDR_OFF1: st_d.prdata = 32'(st_q.off_dly[1]);
				ADDR_INUSE: st_d.prdata = 32'(st_q.in_used);
				ADDR_STATUS: begin
					st_d.prdata[STAT_ACC_LSB +: NUM_OUT] = st_q.acc;
					st_d.prdata[STAT_COND_LSB +: NUM_OUT] = cond;
					st_d.prdata[STAT_RELAY_LSB +: NUM_OUT] = st_q.relay;
					st_d.prdata[STAT_DIN_LSB +: NUM_DIN] = st_q.din_s;
					st_d.pslverr = pwrite;
				end
				default: st_d.pslverr = 1'b1;
			endcase
		end
		if (wr_commit) begin
			case (paddr)
				ADDR_SEL0: st_d.sel[0] = pwdata[SEL_W-1:0];
				ADDR_SEL1: st_d.sel[1] = pwdata[SEL_W-1:0];
				ADDR_LVL0: st_d.level[0] = wl;
				ADDR_LVL1: st_d.level[1] = wl;
				ADDR_ON0: st_d.on_dly[0] = wd;
				ADDR_ON1: st_d.on_dly[1] = wd;
				ADDR_OFF0: st_d.off_dly[0] = wd;
				ADDR_OFF1: st_d.off_dly[1] = wd;
				ADDR_INUSE: st_d.in_used = pwdata[NUM_DIN-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.pslverr;
	assign relay = st_q.relay;
endmodule // dao_top

//--- tb/dao_checker.sv
`timescale 1ns/1ps
module dao_checker
	import dao_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr // APB error
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_req;
		psel && penable && !pready;
	endsequence
	AST_ANSWER: assert property (s_req |=> pready)
		else $error("no ready after access");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error outside answer");
	AST_STATUS_RO: assert property (s_req ##0 (pwrite && paddr == ADDR_STATUS) |=> pslverr)
		else $error("status write accepted");
	AST_UNMAPPED: assert property (s_req ##0 (paddr > ADDR_STATUS) |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property (s_req ##0 (paddr[1:0] == 2'h0 && paddr <= ADDR_INUSE) |=> !pslverr)
		else $error("mapped access refused");
	AST_LVL_RANGE: assert property (s_req ##0 (!pwrite && paddr == ADDR_LVL0) |=> prdata <= 32'h2000)
		else $error("level beyond range");
	AST_DLY_RANGE: assert property (s_req ##0 (!pwrite && paddr == ADDR_ON0) |=> prdata <= 32'h1770)
		else $error("delay beyond range");
endmodule // dao_checker
bind dao_top dao_checker u_dao_checker(.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr));

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
	import dao_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [SEL_COUNT-1:0] status_cond = '0;
	logic [NUM_MON-1:0][LVL_W-1:0] mon_val = '0;
	logic [NUM_DIN-1:0] din = '0;
	logic [NUM_OUT-1:0] relay;
	int failures = 0, n_tests = 0;
	always #4 pclk = ~pclk;
	// Short tick keeps delay scenarios to a few dozen cycles
	dao_top #(.TICK_CYCLES(4)) u_dao_top(.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .status_cond(status_cond), .mon_val(mon_val),
		.din(din), .relay(relay));
	task give_verdict;
		if (failures == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk) penable <= 1;
		k = 0;
		// Look at the answer mid-cycle, where it has settled, then finish on the next rising edge
		do begin
			@(negedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1) begin
			failures++;
			$display("mismatch %0t no ready", $time);
		end
		r = prdata;
		e = pslverr;
		@(posedge pclk);
		psel <= 0; penable <= 0;
		@(posedge pclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task rly(input int n, input logic [1:0] x);
		repeat (n) @(posedge pclk);
		chk({30'h0, relay}, {30'h0, x});
	endtask
	task t_regs;
		rd(ADDR_LVL0, 32'h0, 1'b0);
		rd(ADDR_ON1, 32'h0, 1'b0);
		rd(ADDR_OFF1, 32'h0, 1'b0);
		wr(ADDR_LVL1, 32'h3000); rd(ADDR_LVL1, 32'h2000, 1'b0);
		wr(ADDR_ON0, 32'h1771); rd(ADDR_ON0, 32'h1770, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		wr(ADDR_STATUS, 32'hff); wr(ADDR_ON0, 32'h0);
	endtask
	task t_thresh;
		wr(ADDR_LVL0, 32'h64); mon_val[0] <= 14'h64; wr(ADDR_SEL0, 32'ha); rly(4, 2'h1);
		mon_val[1] <= 14'h64; wr(ADDR_SEL0, 32'hb); rly(4, 2'h0);
		mon_val[1] <= 14'h65; rly(4, 2'h1);
		mon_val[3] <= 14'h32; wr(ADDR_SEL0, 32'hd); rly(4, 2'h0);
		rd(ADDR_LVL0, 32'h64, 1'b0);
	endtask
	task t_link;
		din <= 6'h01; wr(ADDR_SEL1, 32'h15); rly(4, 2'h0);
		wr(ADDR_INUSE, 32'h1); rly(4, 2'h2);
		din <= 6'h00; rly(6, 2'h0);
		wr(ADDR_INUSE, 32'h0); wr(ADDR_SEL1, 32'h0);
	endtask
	task t_delay;
		wr(ADDR_ON0, 32'h3); wr(ADDR_OFF0, 32'h3); wr(ADDR_SEL0, 32'h3);
		status_cond[3] <= 1; rly(6, 2'h0);
		rly(10, 2'h1);
		status_cond[3] <= 0; rly(4, 2'h1);
		status_cond[3] <= 1; rly(20, 2'h1);
		status_cond[3] <= 0; rly(6, 2'h1);
		rly(10, 2'h0);
	endtask
	task t_fault;
		wr(ADDR_ON0, 32'h0); wr(ADDR_OFF0, 32'h0); wr(ADDR_SEL0, 32'h1); rly(4, 2'h1);
		status_cond[1] <= 1; rly(4, 2'h0);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs; t_thresh; t_link; t_delay; t_fault;
		give_verdict;
	end
	initial begin
		#100000;
		failures++;
		give_verdict;
	end
endmodule // tb
